// ==== rtl/frcct_pkg.sv ====
// constants shared by the free-running capture/compare timer files
`default_nettype none

package frcct_pkg;

    // ****************************************************************
    // register byte offsets on the apb bus
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL0 = 8'h00;   // count enable, clock select
    localparam logic [7:0] OFF_CTRL1 = 8'h04;   // mode select field
    localparam logic [7:0] OFF_IOC0 = 8'h08;    // output enable and level bits
    localparam logic [7:0] OFF_IOC1 = 8'h0C;    // capture edge select
    localparam logic [7:0] OFF_OPT0 = 8'h10;    // overflow flag, capture selects
    localparam logic [7:0] OFF_CCR0 = 8'h14;    // capture/compare 0
    localparam logic [7:0] OFF_CCR1 = 8'h18;    // capture/compare 1
    localparam logic [7:0] OFF_COUNT = 8'h1C;   // live counter, read only

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL0_CE_POS = 7;            // count enable bit
    localparam int CTRL0_CKS_LSB = 0;           // 3-bit prescaler select
    localparam int IOC0_OE0_POS = 0;            // output enable 0
    localparam int IOC0_OL0_POS = 1;            // output level 0
    localparam int IOC0_OE1_POS = 2;            // output enable 1
    localparam int IOC0_OL1_POS = 3;            // output level 1
    localparam int IOC1_SEL0_LSB = 0;           // edge select ch 0, 2 bits
    localparam int IOC1_SEL1_LSB = 2;           // edge select ch 1, 2 bits
    localparam int OPT0_OVF_POS = 0;            // overflow flag
    localparam int OPT0_CCS0_POS = 4;           // capture select 0
    localparam int OPT0_CCS1_POS = 5;           // capture select 1

    // ****************************************************************
    // encodings and reset values
    // ****************************************************************
    localparam logic [2:0] MODE_FREE_RUN = 3'h5;    // binary 101
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] EDGE_NONE = 2'h0;        // no edge detected
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [15:0] COUNT_INIT = 16'hFFFF;  // value held while stopped
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;   // last value before wrap
    localparam logic [15:0] CCR_RESET = 16'h0000;
    localparam logic [2:0] CKS_RESET = 3'h0;

endpackage : frcct_pkg

`default_nettype wire

// ==== rtl/frcct_edge_if.sv ====
// edge select and detected-edge pulse between timer core and input stage
`timescale 1ns/1ps
`default_nettype none

interface frcct_edge_if;
    logic [1:0] sel;    // which edge counts as valid
    logic edge_hit;     // one-cycle pulse on a valid edge

    // ****************************************************************
    // modports
    // ****************************************************************
    modport core (output sel, input edge_hit);
    modport detector (input sel, output edge_hit);
endinterface : frcct_edge_if

`default_nettype wire

// ==== rtl/frcct_edge_sync.sv ====
// pin synchroniser with filtered edge detection for one capture input
`timescale 1ns/1ps
`default_nettype none

module frcct_edge_sync
    import frcct_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // capture pin, asynchronous
    input wire logic pin,
    // select in, edge pulse out
    frcct_edge_if.detector bus
);

    logic sync1;    // first stage, read only by sync2
    logic sync2;
    logic sync3;
    logic level;    // accepted pin level
    logic primed;   // first agreement only loads level

    // ****************************************************************
    // three-stage synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end
        else
        begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ****************************************************************
    // accepted level and edge pulse
    // ****************************************************************
    // a change counts only once stages two and three agree; the first
    // agreement after reset loads the level from the reset-cleared stages, so a pin that
    // sits high through reset still gives a rising edge once it reaches stage three
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            level <= 1'b0;
            primed <= 1'b0;
            bus.edge_hit <= 1'b0;
        end
        else
        begin
            bus.edge_hit <= 1'b0;
            if (sync2 == sync3)
            begin
                primed <= 1'b1;
                level <= sync3;
                if (primed && (sync3 != level))
                begin
                    case (bus.sel)
                        EDGE_RISE: bus.edge_hit <= sync3;
                        EDGE_FALL: bus.edge_hit <= !sync3;
                        EDGE_BOTH: bus.edge_hit <= 1'b1;
                        default: bus.edge_hit <= 1'b0;
                    endcase
                end
            end
        end
    end

endmodule // frcct_edge_sync

`default_nettype wire

// ==== rtl/frcct_timer.sv ====
// free-running 16-bit capture/compare timer channel with apb registers
`timescale 1ns/1ps
`default_nettype none

module frcct_timer
    import frcct_pkg::*;
#(
    parameter int ADDR_W = 8    // apb address width
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture input pins
    input wire logic capture_input_0,
    input wire logic capture_input_1,
    // timer output pins
    output logic timer_out_0,
    output logic timer_out_1,
    // event pulses
    output logic overflow_irq,
    output logic [1:0] match_capture_irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic count_enable_bit;         // software run request
    logic [2:0] clk_sel;            // count clock = ref_clk / 2**clk_sel
    logic [2:0] mode_select_field;  // channel mode
    logic [1:0] output_enable_bit;  // per output pin
    logic [1:0] output_level_bit;   // per output pin
    logic [3:0] edge_cfg;           // two bits per capture input
    logic [1:0] capture_select;     // 1 = capture, 0 = compare
    logic overflow_flag;            // sticky overflow
    logic [15:0] capture_compare_reg [2];
    logic [15:0] count;             // the 16-bit counter
    logic started;                  // first count clock seen since start
    logic [7:0] presc;              // prescaler
    logic run_d;                    // run one cycle ago
    logic [1:0] toggle;             // inversion state of each output
    logic run;                      // channel counting
    logic start;                    // first cycle of run
    logic tick;                     // one count clock
    logic ovf_event;                // counter wraps this cycle
    logic [1:0] match;              // compare hits this cycle
    logic [1:0] capture;            // capture strobes this cycle
    logic [1:0] edge_hit;           // valid edges from input stage
    logic acc_write;                // apb write takes effect
    logic setup;                    // apb setup phase
    logic [7:0] waddr;              // word address, low byte

    frcct_edge_if edge_bus [2] ();

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // prescaler mask for a clock select value
    function automatic logic [7:0] presc_mask(input logic [2:0] sel);
        presc_mask = 8'((9'h001 << sel) - 9'h001);
    endfunction

    // register hit check, used by the write decoders; the read mux cases on waddr directly
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // ****************************************************************
    // run control and count clock
    // ****************************************************************
    assign run = count_enable_bit && (mode_select_field == MODE_FREE_RUN);
    assign start = run && !run_d;
    assign tick = run && ((presc & presc_mask(clk_sel)) == presc_mask(clk_sel));
    assign ovf_event = tick && started && (count == COUNT_TOP);

    // remember run to find the enabling edge
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            run_d <= 1'b0;
        else
            run_d <= run;
    end

    // prescaler restarts with each enable so the first count clock is
    // one full period after the start; a stop freezes it at zero
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            presc <= 8'h00;
        else if (!run || tick)
            presc <= 8'h00;
        else
            presc <= presc + 8'h01;
    end

    // ****************************************************************
    // the 16-bit counter
    // ****************************************************************
    // counter sits at FFFFH while stopped and rolls to 0000H on the
    // first count clock; that first roll is not an overflow
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            count <= COUNT_INIT;
        else if (!run)
            count <= COUNT_INIT;
        else if (tick)
            count <= count + 16'h0001;
    end

    // first count clock marker, keeps the start roll quiet
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            started <= 1'b0;
        else if (!run)
            started <= 1'b0;
        else if (tick)
            started <= 1'b1;
    end

    // ****************************************************************
    // compare and capture events
    // ****************************************************************
    // the match fires at the count clock after the counter reached the
    // register value; the register is compared live, never buffered
    generate
        for (genvar m = 0; m < 2; m++)
        begin : g_chan
            assign edge_bus[m].sel = edge_cfg[2*m +: 2];
            assign edge_hit[m] = edge_bus[m].edge_hit;
            assign match[m] = tick && started && !capture_select[m]
                && (count == capture_compare_reg[m]);
            assign capture[m] = run && capture_select[m] && edge_hit[m];
        end
    endgenerate

    frcct_edge_sync u_sync0
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin(capture_input_0),
        .bus(edge_bus[0])
    );

    frcct_edge_sync u_sync1
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin(capture_input_1),
        .bus(edge_bus[1])
    );

    // ****************************************************************
    // event pulses
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            overflow_irq <= 1'b0;
            match_capture_irq <= 2'h0;
        end
        else
        begin
            overflow_irq <= ovf_event;
            match_capture_irq <= match | capture;
        end
    end

    // ****************************************************************
    // timer output pins
    // ****************************************************************
    // toggle is cleared while stopped, so a stopped pin shows the plain
    // level bit; enable sets it, which inverts each enabled pin two cycles after run rises
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            toggle <= 2'h0;
        else if (!run)
            toggle <= 2'h0;
        else if (start)
            toggle <= 2'h3;
        else
            toggle <= toggle ^ match;
    end

    // pins are registered, one cycle behind the toggle state
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            timer_out_0 <= 1'b0;
            timer_out_1 <= 1'b0;
        end
        else
        begin
            timer_out_0 <= output_level_bit[0] ^ (output_enable_bit[0] & toggle[0]);
            timer_out_1 <= output_level_bit[1] ^ (output_enable_bit[1] & toggle[1]);
        end
    end

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign setup = psel && !penable;
    assign acc_write = psel && penable && pwrite;
    assign waddr = {paddr[7:2], 2'b00};
    assign pready = 1'b1;                       // zero wait states

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            count_enable_bit <= 1'b0;
            clk_sel <= CKS_RESET;
            mode_select_field <= MODE_RESET;
            output_enable_bit <= 2'h0;
            output_level_bit <= 2'h0;
            edge_cfg <= {EDGE_NONE, EDGE_NONE};
            capture_select <= 2'h0;
        end
        else if (acc_write && pstrb[0])
        begin
            if (reg_hit(waddr, OFF_CTRL0))
            begin
                count_enable_bit <= pwdata[CTRL0_CE_POS];
                clk_sel <= pwdata[CTRL0_CKS_LSB +: 3];
            end
            if (reg_hit(waddr, OFF_CTRL1))
                mode_select_field <= pwdata[2:0];
            if (reg_hit(waddr, OFF_IOC0))
            begin
                output_enable_bit <= {pwdata[IOC0_OE1_POS], pwdata[IOC0_OE0_POS]};
                output_level_bit <= {pwdata[IOC0_OL1_POS], pwdata[IOC0_OL0_POS]};
            end
            if (reg_hit(waddr, OFF_IOC1))
                edge_cfg <= {pwdata[IOC1_SEL1_LSB +: 2], pwdata[IOC1_SEL0_LSB +: 2]};
            if (reg_hit(waddr, OFF_OPT0))
                capture_select <= {pwdata[OPT0_CCS1_POS], pwdata[OPT0_CCS0_POS]};
        end
    end

    // ****************************************************************
    // overflow flag
    // ****************************************************************
    // software writing 1 never sets it; a clear in the same cycle as a
    // wrap loses, so an overflow is never dropped by a clear
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            overflow_flag <= 1'b0;
        else if (ovf_event)
            overflow_flag <= 1'b1;
        else if (acc_write && pstrb[0] && reg_hit(waddr, OFF_OPT0) && !pwdata[OPT0_OVF_POS])
            overflow_flag <= 1'b0;
    end

    // ****************************************************************
    // capture/compare registers
    // ****************************************************************
    // capture beats a software write in the same cycle
    generate
        for (genvar m = 0; m < 2; m++)
        begin : g_ccr
            always_ff @(posedge ref_clk)
            begin
                if (!nrst)
                    capture_compare_reg[m] <= CCR_RESET;
                else if (capture[m])
                    capture_compare_reg[m] <= count;
                else if (acc_write && reg_hit(waddr, (m == 0) ? OFF_CCR0 : OFF_CCR1))
                begin
                    if (pstrb[0])
                        capture_compare_reg[m][7:0] <= pwdata[7:0];
                    if (pstrb[1])
                        capture_compare_reg[m][15:8] <= pwdata[15:8];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // read data and error response
    // ****************************************************************
    // read data is registered in the setup phase; unmapped addresses
    // answer zero with pslverr in the access phase
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            case (waddr)
                OFF_CTRL0: prdata <= {24'h000000, count_enable_bit, 4'h0, clk_sel};
                OFF_CTRL1: prdata <= {29'h00000000, mode_select_field};
                OFF_IOC0: prdata <= {28'h0000000, output_level_bit[1], output_enable_bit[1],
                    output_level_bit[0], output_enable_bit[0]};
                OFF_IOC1: prdata <= {28'h0000000, edge_cfg};
                OFF_OPT0: prdata <= {26'h0000000, capture_select, 3'h0, overflow_flag};
                OFF_CCR0: prdata <= {16'h0000, capture_compare_reg[0]};
                OFF_CCR1: prdata <= {16'h0000, capture_compare_reg[1]};
                OFF_COUNT: prdata <= {16'h0000, count};
                default: pslverr <= 1'b1;
            endcase
            if (paddr[1:0] != 2'b00)
                pslverr <= 1'b1;
        end
    end

endmodule // frcct_timer

`default_nettype wire

// ==== test/frcct_timer_props.sv ====
// port-level assertions for the free-running capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module frcct_timer_chk
    import frcct_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb requests
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // pins and events
    input wire logic timer_out_0,
    input wire logic timer_out_1,
    input wire logic overflow_irq,
    input wire logic [1:0] match_capture_irq
);
    // ****
    // shadows of the control bits, taken from bus writes
    // ****
    logic wr; // a write lands at this edge
    logic ce; // count enable
    logic [2:0] mode; // mode field
    logic [3:0] ioc; // output enable and level bits
    logic [1:0] csel; // capture selects
    logic [1:0] quiet; // edges since the last write, saturating
    logic [16:0] since; // cycles of running, saturating at 10000H
    logic run;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign run = ce && (mode == MODE_FREE_RUN);
    // shadow registers follow the bus, cleared by reset
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || (wr && paddr[7:0] == OFF_CTRL0))
            ce <= nrst && pwdata[CTRL0_CE_POS];
        if (!nrst || (wr && paddr[7:0] == OFF_CTRL1))
            mode <= nrst ? pwdata[2:0] : MODE_RESET;
        if (!nrst || (wr && paddr[7:0] == OFF_IOC0))
            ioc <= nrst ? pwdata[3:0] : 4'h0;
        if (!nrst || (wr && paddr[7:0] == OFF_OPT0))
            csel <= nrst ? pwdata[5:4] : 2'h0;
    end
    // settle counters give the registered outputs time to follow a write
    always_ff @(posedge ref_clk)
        quiet <= (!nrst || wr) ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    always_ff @(posedge ref_clk)
        since <= (!nrst || !run) ? 17'h0 : (since[16] ? since : since + 17'h1);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    start_out_a: assert property ($rose(run) |-> ##2
        (timer_out_0 == (ioc[1] ^ ioc[0]) && timer_out_1 == (ioc[3] ^ ioc[2])))
        else $error("outputs did not invert at start");
    stop_level_a: assert property (!run && quiet == 2'h3 |->
        timer_out_0 == ioc[1] && timer_out_1 == ioc[3]) else $error("stopped output off its level bit");
    stop_quiet_a: assert property (!run && quiet == 2'h3 |->
        !overflow_irq && match_capture_irq == 2'h0) else $error("event while stopped");
    // the pin is registered behind the toggle, so it flips one cycle after the match pulse
    toggle_zero_a: assert property (run && quiet == 2'h3 |->
        (timer_out_0 != $past(timer_out_0)) == ($past(match_capture_irq[0]) && ioc[0] && !csel[0]))
        else $error("output 0 toggle not tied to compare match");
    toggle_one_a: assert property (run && quiet == 2'h3 |->
        (timer_out_1 != $past(timer_out_1)) == ($past(match_capture_irq[1]) && ioc[2] && !csel[1]))
        else $error("output 1 toggle not tied to compare match");
    ovf_late_a: assert property (overflow_irq |-> since[16])
        else $error("overflow before a full counter cycle");
    ovf_pulse_a: assert property (overflow_irq |=> !overflow_irq [*8])
        else $error("overflow pulse too long");
    match_pulse_a: assert property (match_capture_irq[0] && !csel[0] |=> !match_capture_irq[0])
        else $error("compare pulse too long");

    cover property (overflow_irq);
    cover property (match_capture_irq[0] && csel[0]);
    cover property ($rose(run));
endmodule // frcct_timer_chk

bind frcct_timer frcct_timer_chk #(.ADDR_W(ADDR_W)) chk (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .timer_out_0, .timer_out_1, .overflow_irq, .match_capture_irq);
`default_nettype wire

// ==== test/frcct_pin_model.sv ====
// far side: the two capture pins, driven by a source outside the chip
`timescale 1ns/1ps
`default_nettype none
module frcct_pin_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // flip requests in, pin levels out
    input wire logic [1:0] flip,
    output logic [1:0] pins
);
    // pins rest low; a request makes one clean edge, never a glitch
    always_ff @(posedge ref_clk)
        pins <= !nrst ? 2'h0 : pins ^ flip;
endmodule // frcct_pin_model
`default_nettype wire

// ==== test/frcct_timer_test.sv ====
// self-checking bench for the free-running capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module frcct_timer_test
    import frcct_pkg::*;
;
    logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [1:0] flip = 2'h0, pins, match_capture_irq;
    logic pready, pslverr, timer_out_0, timer_out_1, overflow_irq;
    int miscompares = 0, total_checks = 0, cyc = 0;
    int ev_cnt [3] = '{0, 0, 0}; // per-channel and overflow counts kept apart

    frcct_timer uut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .capture_input_0(pins[0]), .capture_input_1(pins[1]), .timer_out_0, .timer_out_1,
        .overflow_irq, .match_capture_irq);
    frcct_pin_model far (.ref_clk, .nrst, .flip, .pins);

    initial forever #4 ref_clk = !ref_clk;
    // event counting and the hang limit
    always @(posedge ref_clk)
    begin
        ev_cnt[0] <= ev_cnt[0] + (match_capture_irq[0] === 1'b1);
        ev_cnt[1] <= ev_cnt[1] + (match_capture_irq[1] === 1'b1);
        ev_cnt[2] <= ev_cnt[2] + (overflow_irq === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // one apb transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic wait_ev(input int k, input int n);
        for (int t = 0; t < 70000 && ev_cnt[k] < n; t++)
            @(posedge ref_clk);
        chk(32'(ev_cnt[k] >= n), 32'h1);
    endtask
    task automatic pulse(input logic [1:0] f);
        @(posedge ref_clk);
        flip <= f;
        @(posedge ref_clk);
        flip <= 2'h0;
        repeat (12) @(posedge ref_clk);
    endtask

    initial
    begin
        logic [31:0] q, c;
        logic e;
        int exp_hits [4] = '{0, 1, 1, 2};
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(OFF_COUNT, 32'hFFFF);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        // enable under the reset mode: counter must stay put
        wr(OFF_CTRL0, 32'h80);
        rd(OFF_COUNT, 32'hFFFF);
        wr(OFF_CTRL0, 32'h0);
        // both channels compare, outputs enabled and low
        wr(OFF_IOC0, 32'h5);
        wr(OFF_CCR0, 32'h10);
        wr(OFF_CCR1, 32'h200);
        wr(OFF_CTRL1, {29'h0, MODE_FREE_RUN});
        wr(OFF_CTRL0, 32'h80);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, timer_out_1, timer_out_0}, 32'h3);
        wait_ev(0, 1);
        chk({31'h0, timer_out_0}, 32'h0);
        wr(OFF_CCR0, 32'h21);
        wait_ev(0, 2);
        apb(1'b0, OFF_COUNT, 32'h0, q, e);
        chk_rng(q, 32'h22, 32'h40);
        wait_ev(1, 1);
        chk({31'h0, timer_out_1}, 32'h0);
        wait_ev(2, 1);
        apb(1'b0, OFF_COUNT, 32'h0, q, e);
        chk_rng(q, 32'h0, 32'h10);
        rd(OFF_OPT0, 32'h1);
        wr(OFF_OPT0, 32'h1);
        rd(OFF_OPT0, 32'h1);
        wr(OFF_OPT0, 32'h0);
        rd(OFF_OPT0, 32'h0);
        // channel 0 capture checked under every edge setting, none expecting no capture, rise then fall each
        wr(OFF_OPT0, 32'h10);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_IOC1, 32'(m));
            c = ev_cnt[0];
            pulse(2'h1);
            pulse(2'h1);
            chk(ev_cnt[0] - c, exp_hits[m]);
        end
        apb(1'b0, OFF_CCR0, 32'h0, c, e);
        apb(1'b0, OFF_COUNT, 32'h0, q, e);
        chk_rng(q - c, 32'h1, 32'h40);
        // width between two captures: pin edges twenty cycles apart
        pulse(2'h1);
        apb(1'b0, OFF_CCR0, 32'h0, q, e);
        chk_rng(q - c, 32'h10, 32'h20);
        // channel 1 capture with no edge selected keeps its value
        wr(OFF_OPT0, 32'h30);
        pulse(2'h2);
        pulse(2'h2);
        rd(OFF_CCR1, 32'h200);
        // stop: counter back to start, outputs rest at level bits
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_IOC0, 32'hF);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, timer_out_1, timer_out_0}, 32'h3);
        rd(OFF_COUNT, 32'hFFFF);
        wr(OFF_CTRL0, 32'h80);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, timer_out_1, timer_out_0}, 32'h0);
        end_of_test();
    end
endmodule // frcct_timer_test
`default_nettype wire
